//--- dv/slt_lane_test_status_tb.sv
// Testbench for the serial-lane test status block: bus tasks and scenarios.
// Assumes the logic/ package and design files are compiled first.
`timescale 1ns/1ps
`default_nettype none
module slt_lane_test_status_tb;
    // Short counters so saturation shows without a long run
    localparam int CW = 4;
    localparam logic [31:0] CMAX = 32'h_0000_000f;
    logic clk = 1'b0;
    logic reset = 1'b1;
    logic [7:0] avs_address = 8'h_00;
    logic avs_read = 1'b0;
    logic avs_write = 1'b0;
    logic [31:0] avs_writedata = 32'h_0000_0000;
    logic [3:0] avs_byteenable = 4'h_f;
    logic [31:0] avs_readdata;
    logic avs_waitrequest;
    logic [23:0] laneErr = 24'h_00_0000;
    logic [23:0] laneSynced = 24'h_00_0000;
    logic txResyncPulse;
    logic rxResyncPulse;
    logic [23:0] laneQuiet;
    logic irq;
    logic [31:0] rdData;
    int n_mismatch = 0;
    int tests_run = 0;
    int nTx = 0;
    int nRx = 0;
    int txBefore;
    int rxBefore;

    always #5 clk = ~clk;

    slt_lane_test_status #(.CNT_W(CW)) u_dut (
        .clk(clk),
        .reset(reset),
        .avs_address(avs_address),
        .avs_read(avs_read),
        .avs_write(avs_write),
        .avs_writedata(avs_writedata),
        .avs_byteenable(avs_byteenable),
        .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest),
        .laneErr(laneErr),
        .laneSynced(laneSynced),
        .txResyncPulse(txResyncPulse),
        .rxResyncPulse(rxResyncPulse),
        .laneQuiet(laneQuiet),
        .irq(irq)
    );

    // Pulses last one cycle, so count them at every edge
    always @(posedge clk) begin
        if (txResyncPulse === 1'b1) nTx <= nTx + 1;
        if (rxResyncPulse === 1'b1) nRx <= nRx + 1;
    end

    task automatic wrap_up();
        if (n_mismatch == 0 && tests_run > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask : wrap_up

    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("wrong value %s expected %h seen %h", what, exp, seen);
        end
    endtask : check

    // Request held until waitrequest is sampled low; bounded wait
    task automatic bus_op(input logic wr, input logic [7:0] addr, input logic [31:0] data,
                          input logic [3:0] be);
        int n;
        n = 0;
        @(posedge clk);
        avs_address <= addr;
        avs_writedata <= data;
        avs_byteenable <= be;
        avs_write <= wr;
        avs_read <= ~wr;
        do begin
            @(posedge clk);
            n++;
        end while (avs_waitrequest !== 1'b0 && n < 64);
        rdData = avs_readdata;
        avs_read <= 1'b0;
        avs_write <= 1'b0;
        if (avs_waitrequest !== 1'b0) begin
            n_mismatch++;
            $display("wrong value waitrequest expected 0 seen %b", avs_waitrequest);
        end
    endtask : bus_op

    task automatic wr(input logic [7:0] addr, input logic [31:0] data);
        bus_op(1'b1, addr, data, 4'h_f);
    endtask : wr

    task automatic rd_chk(input logic [7:0] addr, input logic [31:0] exp, input string what);
        bus_op(1'b0, addr, 32'h_0000_0000, 4'h_f);
        check(what, rdData, exp);
    endtask : rd_chk

    // Lane inputs held for a known count, then idle long enough to settle
    task automatic drive_lanes(input logic [23:0] err, input logic [23:0] syn, input int cyc);
        @(posedge clk);
        laneErr <= err;
        laneSynced <= syn;
        repeat (cyc) @(posedge clk);
        laneErr <= 24'h_00_0000;
        laneSynced <= 24'h_00_0000;
        repeat (8) @(posedge clk);
    endtask : drive_lanes

    initial begin
        repeat (20000) @(posedge clk);
        n_mismatch++;
        wrap_up();
    end

    initial begin
        repeat (2) @(posedge clk);
        reset <= 1'b0;
        rd_chk(slt_pkg::OFF_CONTROL, {8'h_00, slt_pkg::RESET_ENABLE}, "control reset");
        rd_chk(slt_pkg::OFF_FAIL, 32'h_0000_0000, "fail reset");
        rd_chk(slt_pkg::OFF_SYNC, 32'h_0000_0000, "sync reset");
        rd_chk(slt_pkg::OFF_SELECT, 32'h_0000_0000, "select reset");
        rd_chk(slt_pkg::OFF_COUNT0, 32'h_0000_0000, "count reset");
        rd_chk(8'h_40, slt_pkg::UNMAPPED_DATA, "unmapped read");
        wr(slt_pkg::OFF_CONTROL, 32'h_feff_ffff);
        rd_chk(slt_pkg::OFF_CONTROL, 32'h_00ff_ffff, "control readback");
        for (int m = 0; m < 4; m++) begin
            wr(slt_pkg::OFF_MODE, 32'(m));
            txBefore = nTx;
            rxBefore = nRx;
            wr(slt_pkg::OFF_CONTROL, 32'h_02ff_ffff);
            repeat (4) @(posedge clk);
            check("tx pulses", 32'(nTx - txBefore), (m == 1 || m == 2) ? 1 : 0);
            check("rx quiet", 32'(nRx - rxBefore), 32'h_0000_0000);
            wr(slt_pkg::OFF_CONTROL, 32'h_04ff_ffff);
            repeat (4) @(posedge clk);
            check("rx pulses", 32'(nRx - rxBefore), (m == 1 || m == 2) ? 1 : 0);
            rd_chk(slt_pkg::OFF_CONTROL, 32'h_00ff_ffff, "trigger reads zero");
        end
        // PRBS mode with lane 1 of port A left out
        wr(slt_pkg::OFF_MODE, 32'h_0000_0002);
        wr(slt_pkg::OFF_CONTROL, 32'h_00ff_fffd);
        repeat (3) @(posedge clk);
        check("quiet lanes", {8'h_00, laneQuiet}, 32'h_0000_0002);
        drive_lanes(24'h_08_8003, 24'h_80_0106, 3);
        rd_chk(slt_pkg::OFF_FAIL, 32'h_0008_8001, "fail flags");
        rd_chk(slt_pkg::OFF_SYNC, 32'h_0080_0104, "sync flags");
        wr(slt_pkg::OFF_FAIL, 32'h_0000_0001);
        rd_chk(slt_pkg::OFF_FAIL, 32'h_0008_8000, "fail one cleared");
        wr(slt_pkg::OFF_FAIL, 32'h_0000_0000);
        rd_chk(slt_pkg::OFF_FAIL, 32'h_0008_8000, "fail zero write");
        wr(slt_pkg::OFF_SYNC, 32'h_ff80_0004);
        rd_chk(slt_pkg::OFF_SYNC, 32'h_0000_0100, "sync partly cleared");
        // Masked status must not reach the pin
        check("irq masked", {31'h_0, irq}, 32'h_0000_0000);
        wr(slt_pkg::OFF_IRQ_MASK, 32'h_0000_0001);
        repeat (2) @(posedge clk);
        check("irq unmasked", {31'h_0, irq}, 32'h_0000_0001);
        wr(slt_pkg::OFF_IRQ_STATUS, 32'h_0000_0001);
        repeat (2) @(posedge clk);
        check("irq cleared", {31'h_0, irq}, 32'h_0000_0000);
        rd_chk(slt_pkg::OFF_IRQ_STATUS, 32'h_0000_0002, "irq status");
        // Outside test mode no lane is quiet and errors are not flagged
        wr(slt_pkg::OFF_MODE, 32'h_0000_0000);
        repeat (3) @(posedge clk);
        check("quiet in normal", {8'h_00, laneQuiet}, 32'h_0000_0000);
        drive_lanes(24'h_00_0010, 24'h_00_0000, 2);
        rd_chk(slt_pkg::OFF_FAIL, 32'h_0008_8000, "no flag in normal");
        wr(slt_pkg::OFF_FAIL, 32'h_ffff_ffff);
        rd_chk(slt_pkg::OFF_FAIL, 32'h_0000_0000, "fail all cleared");
        // Counters: B lane 3, C lane 0, A lane 7
        wr(slt_pkg::OFF_MODE, 32'h_0000_0002);
        wr(slt_pkg::OFF_CONTROL, 32'h_00ff_ffff);
        wr(slt_pkg::OFF_SELECT, 32'h_0000_1e0b);
        rd_chk(slt_pkg::OFF_SELECT, 32'h_0000_1e0b, "select readback");
        bus_op(1'b0, slt_pkg::OFF_COUNT0, 32'h_0000_0000, 4'h_f);
        bus_op(1'b0, slt_pkg::OFF_COUNT1, 32'h_0000_0000, 4'h_f);
        drive_lanes(24'h_00_0808, 24'h_00_0000, 5);
        drive_lanes(24'h_01_0000, 24'h_00_0000, 2);
        drive_lanes(24'h_00_0080, 24'h_00_0000, 3);
        rd_chk(slt_pkg::OFF_COUNT0, 32'h_0002_0005, "count pair 0");
        rd_chk(slt_pkg::OFF_COUNT1, 32'h_0000_0003, "count pair 1");
        rd_chk(slt_pkg::OFF_COUNT0, 32'h_0000_0000, "clear on read");
        drive_lanes(24'h_00_0800, 24'h_00_0000, 20);
        rd_chk(slt_pkg::OFF_COUNT0, CMAX, "count saturates");
        wr(slt_pkg::OFF_SELECT, 32'h_0000_7e0b);
        drive_lanes(24'h_00_0080, 24'h_00_0000, 3);
        rd_chk(slt_pkg::OFF_COUNT1, 32'h_0000_0000, "reserved port counts nothing");
        wr(slt_pkg::OFF_MODE, 32'h_0000_0000);
        drive_lanes(24'h_00_0800, 24'h_00_0000, 3);
        rd_chk(slt_pkg::OFF_COUNT0, 32'h_0000_0000, "no count in normal");
        bus_op(1'b1, slt_pkg::OFF_SELECT, 32'h_0000_7fff, 4'h_2);
        rd_chk(slt_pkg::OFF_SELECT, 32'h_0000_7f0b, "select byte lane");
        wrap_up();
    end
endmodule : slt_lane_test_status_tb
`default_nettype wire

//--- logic/slt_err_counter.sv
// One saturating lane error counter with clear on read.
// Assumes error bits are synchronous to clk.
`timescale 1ns/1ps
`default_nettype none
module slt_err_counter #(
    parameter int W = 16
) (
    input wire logic clk,
    input wire logic reset,
    input wire logic active,
    input wire slt_pkg::slt_sel_t sel,
    input wire logic [slt_pkg::ALL_LANES-1:0] laneErr,
    input wire logic readClear,
    output logic [W-1:0] count
);
    logic hit;
    always_comb begin
        hit = 1'b0;
        if (sel.port != slt_pkg::SLT_PORT_RSVD) begin
            hit = laneErr[{sel.port, sel.lane}];
        end
    end

    // Clear on read wins; the hit in that cycle is counted afresh
    always_ff @(posedge clk) begin
        if (reset) begin
            count <= W'(slt_pkg::RESET_COUNT);
        end else if (readClear) begin
            count <= (active && hit) ? W'(1) : W'(0);
        end else if (active && hit && count != {W{1'b1}}) begin
            count <= count + W'(1);
        end
    end

    a_count_saturates: assert property (@(posedge clk) disable iff (reset)
        (count == {W{1'b1}} && !readClear) |=> count == {W{1'b1}})
        else $error("counter wrapped past maximum");
endmodule : slt_err_counter
`default_nettype wire

//--- logic/slt_lane_gate.sv
// Per-lane gating: enabled lanes pass sync status, and errors only in test mode; disabled ones go quiet in test mode.
// Assumes lane status inputs are already on clk.
`timescale 1ns/1ps
`default_nettype none
module slt_lane_gate (
    input wire logic clk,
    input wire logic reset,
    input wire logic testActive,
    input wire logic [slt_pkg::ALL_LANES-1:0] laneEnable,
    input wire slt_pkg::slt_lane_stat_t rawStat,
    output slt_pkg::slt_lane_stat_t gatedStat,
    output logic [slt_pkg::ALL_LANES-1:0] laneQuiet
);
    for (genvar i = 0; i < slt_pkg::ALL_LANES; i++) begin : g_lane
        always_ff @(posedge clk) begin
            if (reset) begin
                gatedStat.err[i] <= 1'b0;
                gatedStat.synced[i] <= 1'b0;
                laneQuiet[i] <= 1'b0;
            end else begin
                gatedStat.err[i] <= testActive && laneEnable[i] && rawStat.err[i];
                gatedStat.synced[i] <= laneEnable[i] && rawStat.synced[i];
                laneQuiet[i] <= testActive && !laneEnable[i];
            end
        end
    end
endmodule : slt_lane_gate
`default_nettype wire

//--- logic/slt_lane_test_status.sv
// Register block for serial-lane test: re-sync triggers, sticky flags, counters.
// Assumes an Avalon-MM master on clk and lane status bits from the lane logic.
//
// What this block does
// - Writing tx re-sync one in sync test mode restarts every lane generator.
// - Writing rx re-sync one in sync test mode restarts every lane checker.
// - Both re-sync bits are write-one triggers and always read zero.
// - Error on an enabled lane in test mode sets its port's failure flag.
// - Flag bit n of each port byte belongs to lane n.
// - Failure flags hold until written one; zero writes ignored; reset zero.
// - Enabled lane reaching checker sync sets its sync-achieved flag.
// - Sync flags clear on written one, reset zero; top byte reads zero.
// - Each counter's three-bit lane select picks the lane within chosen port.
// - Port select: 0 is A, 1 is B, 2 is C, 3 reserved.
// - Selectors 0,1 feed count pair 0; selector 2 feeds pair 1 low half.
// - Control bits above re-sync are reserved, read zero; re-sync resets zero.
// - Counts are 16 bits, count errors in test mode, saturate, clear on read.
// - Disabled lanes in test mode ignore input and hold output quiet.
`timescale 1ns/1ps
`default_nettype none
module slt_lane_test_status #(
    parameter int CNT_W = slt_pkg::CNT_W
) (
    input wire logic clk,
    input wire logic reset,
    input wire logic [7:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    input wire logic [slt_pkg::ALL_LANES-1:0] laneErr,
    input wire logic [slt_pkg::ALL_LANES-1:0] laneSynced,
    output logic txResyncPulse,
    output logic rxResyncPulse,
    output logic [slt_pkg::ALL_LANES-1:0] laneQuiet,
    output logic irq
);
    localparam int N = slt_pkg::ALL_LANES;

    function automatic logic [31:0] byteMask(input logic [3:0] be);
        byteMask = {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}};
    endfunction : byteMask

    function automatic logic syncMode(input slt_pkg::slt_mode_t m);
        syncMode = (m == slt_pkg::SLT_MODE_PATTERN) || (m == slt_pkg::SLT_MODE_PRBS);
    endfunction : syncMode

    // Registers
    logic [N-1:0] laneEnable_r;
    logic [N-1:0] failFlags_r;
    logic [N-1:0] syncFlags_r;
    logic [slt_pkg::SELECT_W-1:0] select_r;
    slt_pkg::slt_mode_t mode_r;
    logic [slt_pkg::IRQ_W-1:0] irqStatus_r;
    logic [slt_pkg::IRQ_W-1:0] irqMask_r;
    logic ack_r;

    // Bus handshake: one wait cycle, then the answer
    logic access;
    logic wrDo;
    logic rdDo;
    logic [31:0] wMask;
    logic [31:0] wOnes;
    assign access = (avs_read || avs_write) && !ack_r;
    assign wrDo = avs_write && ack_r;
    // Read taken where readdata is captured, so clear on read loses no hit
    assign rdDo = avs_read && access;
    assign wMask = byteMask(avs_byteenable);
    assign wOnes = avs_writedata & wMask;

    always_ff @(posedge clk) begin
        if (reset) begin
            ack_r <= 1'b0;
        end else begin
            ack_r <= access;
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            avs_waitrequest <= 1'b1;
        end else begin
            avs_waitrequest <= !access;
        end
    end

    a_wait_single: assert property (@(posedge clk) disable iff (reset)
        ((avs_read || avs_write) && avs_waitrequest) |=> !avs_waitrequest)
        else $error("more than one wait cycle");

    // Synchronise lane status pins before use
    slt_pkg::slt_lane_stat_t syncA_r;
    slt_pkg::slt_lane_stat_t syncB_r;
    slt_pkg::slt_lane_stat_t gated;
    logic testActive;
    assign testActive = (mode_r != slt_pkg::SLT_MODE_NORMAL);

    always_ff @(posedge clk) begin
        if (reset) begin
            syncA_r <= '0;
            syncB_r <= '0;
        end else begin
            syncA_r <= {laneErr, laneSynced};
            syncB_r <= syncA_r;
        end
    end

    slt_lane_gate u_gate (
        .clk(clk),
        .reset(reset),
        .testActive(testActive),
        .laneEnable(laneEnable_r),
        .rawStat(syncB_r),
        .gatedStat(gated),
        .laneQuiet(laneQuiet)
    );

    a_lane_quiet: assert property (@(posedge clk) disable iff (reset)
        (testActive && !laneEnable_r[1]) |=> laneQuiet[1])
        else $error("disabled lane not held quiet");

    a_quiet_no_flag: assert property (@(posedge clk) disable iff (reset)
        !laneEnable_r[1] |=> !gated.err[1])
        else $error("disabled lane passed an error");

    a_fail_in_test: assert property (@(posedge clk) disable iff (reset)
        !testActive |=> !gated.err[0])
        else $error("error passed outside test mode");

    // Control: lane enables and test mode
    always_ff @(posedge clk) begin
        if (reset) begin
            laneEnable_r <= slt_pkg::RESET_ENABLE;
        end else if (wrDo && avs_address == slt_pkg::OFF_CONTROL) begin
            laneEnable_r <= (laneEnable_r & ~wMask[N-1:0]) | wOnes[N-1:0];
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            mode_r <= slt_pkg::SLT_MODE_NORMAL;
        end else if (wrDo && avs_address == slt_pkg::OFF_MODE && avs_byteenable[0]) begin
            mode_r <= slt_pkg::slt_mode_t'(avs_writedata[1:0]);
        end
    end

    // Re-sync strobes: single pulses, never stored as readable state
    always_ff @(posedge clk) begin
        if (reset) begin
            txResyncPulse <= 1'b0;
            rxResyncPulse <= 1'b0;
        end else begin
            txResyncPulse <= wrDo && avs_address == slt_pkg::OFF_CONTROL && syncMode(mode_r)
                && wOnes[slt_pkg::BIT_TX_RESYNC];
            rxResyncPulse <= wrDo && avs_address == slt_pkg::OFF_CONTROL && syncMode(mode_r)
                && wOnes[slt_pkg::BIT_RX_RESYNC];
        end
    end

    // One write takes two cycles, so a strobe can never last two
    a_tx_one_shot: assert property (@(posedge clk) disable iff (reset)
        txResyncPulse |=> !txResyncPulse)
        else $error("tx re-sync longer than one cycle");

    a_rx_one_shot: assert property (@(posedge clk) disable iff (reset)
        rxResyncPulse |=> !rxResyncPulse)
        else $error("rx re-sync longer than one cycle");

    // Sticky flags: set wins over a same-cycle clear
    logic failClr;
    logic syncClr;
    assign failClr = wrDo && avs_address == slt_pkg::OFF_FAIL;
    assign syncClr = wrDo && avs_address == slt_pkg::OFF_SYNC;

    always_ff @(posedge clk) begin
        if (reset) begin
            failFlags_r <= slt_pkg::RESET_FLAGS;
        end else begin
            failFlags_r <= (failFlags_r & ~(failClr ? wOnes[N-1:0] : '0)) | gated.err;
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            syncFlags_r <= slt_pkg::RESET_FLAGS;
        end else begin
            syncFlags_r <= (syncFlags_r & ~(syncClr ? wOnes[N-1:0] : '0)) | gated.synced;
        end
    end

    a_fail_sticky: assert property (@(posedge clk) disable iff (reset)
        (failFlags_r[0] && !(failClr && wOnes[0])) |=> failFlags_r[0])
        else $error("failure flag dropped without a clear");

    a_sync_clear: assert property (@(posedge clk) disable iff (reset)
        (syncClr && wOnes[2] && !gated.synced[2]) |=> !syncFlags_r[2])
        else $error("sync flag survived a write of one");

    a_sync_sticky: assert property (@(posedge clk) disable iff (reset)
        (syncFlags_r[23] && !(syncClr && wOnes[23])) |=> syncFlags_r[23])
        else $error("sync flag dropped without a clear");

    a_sync_sets: assert property (@(posedge clk) disable iff (reset)
        gated.synced[8] |=> syncFlags_r[8])
        else $error("lane sync not flagged");

    // Lane n of each port byte lands in flag bit n
    a_flag_lane_map: assert property (@(posedge clk) disable iff (reset)
        $rose(failFlags_r[19]) |-> $past(gated.err[19]))
        else $error("failure flag set by another lane");

    // Counter selectors
    always_ff @(posedge clk) begin
        if (reset) begin
            select_r <= slt_pkg::RESET_SELECT;
        end else if (wrDo && avs_address == slt_pkg::OFF_SELECT) begin
            select_r <= (select_r & ~wMask[slt_pkg::SELECT_W-1:0])
                | wOnes[slt_pkg::SELECT_W-1:0];
        end
    end

    logic [CNT_W-1:0] count [slt_pkg::NSEL];
    logic [slt_pkg::NSEL-1:0] cntClr;
    assign cntClr[0] = rdDo && avs_address == slt_pkg::OFF_COUNT0;
    assign cntClr[1] = rdDo && avs_address == slt_pkg::OFF_COUNT0;
    assign cntClr[2] = rdDo && avs_address == slt_pkg::OFF_COUNT1;

    for (genvar k = 0; k < slt_pkg::NSEL; k++) begin : g_cnt
        slt_err_counter #(.W(CNT_W)) u_cnt (
            .clk(clk),
            .reset(reset),
            .active(testActive),
            .sel(select_r[k*slt_pkg::SEL_STRIDE +: slt_pkg::SEL_STRIDE]),
            .laneErr(gated.err),
            .readClear(cntClr[k]),
            .count(count[k])
        );
    end

    a_count0_clears: assert property (@(posedge clk) disable iff (reset)
        cntClr[0] |=> (count[0] == '0 || count[0] == CNT_W'(1)))
        else $error("count 0 not cleared by its read");

    a_count2_clears: assert property (@(posedge clk) disable iff (reset)
        cntClr[2] |=> (count[2] == '0 || count[2] == CNT_W'(1)))
        else $error("count 2 not cleared by its read");

    // Interrupt: fail and sync events, write one to clear
    logic [slt_pkg::IRQ_W-1:0] irqEvent;
    logic [slt_pkg::IRQ_W-1:0] irqClr;
    assign irqEvent = {|gated.synced, |gated.err};
    assign irqClr = (wrDo && avs_address == slt_pkg::OFF_IRQ_STATUS)
        ? wOnes[slt_pkg::IRQ_W-1:0] : '0;

    always_ff @(posedge clk) begin
        if (reset) begin
            irqStatus_r <= '0;
        end else begin
            irqStatus_r <= (irqStatus_r & ~irqClr) | irqEvent;
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            irqMask_r <= '0;
        end else if (wrDo && avs_address == slt_pkg::OFF_IRQ_MASK) begin
            irqMask_r <= (irqMask_r & ~wMask[slt_pkg::IRQ_W-1:0])
                | wOnes[slt_pkg::IRQ_W-1:0];
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            irq <= 1'b0;
        end else begin
            irq <= |((irqStatus_r & ~irqClr | irqEvent) & irqMask_r);
        end
    end

    a_irq_level: assert property (@(posedge clk) disable iff (reset)
        ((irqStatus_r & irqMask_r & ~irqClr) != '0) |=> irq)
        else $error("unmasked status did not raise irq");

    // Read mux; reserved and trigger bits read zero
    logic [31:0] rdNxt;
    always_comb begin
        rdNxt = slt_pkg::UNMAPPED_DATA;
        case (avs_address)
            slt_pkg::OFF_CONTROL: rdNxt = {8'h_00, laneEnable_r};
            slt_pkg::OFF_FAIL: rdNxt = {8'h_00, failFlags_r};
            slt_pkg::OFF_SYNC: rdNxt = {8'h_00, syncFlags_r};
            slt_pkg::OFF_SELECT: rdNxt = {17'h_0_0000, select_r};
            slt_pkg::OFF_COUNT0: rdNxt = {16'(count[1]), 16'(count[0])};
            slt_pkg::OFF_COUNT1: rdNxt = {16'h_0000, 16'(count[2])};
            slt_pkg::OFF_MODE: rdNxt = {30'h_0000_0000, mode_r};
            slt_pkg::OFF_IRQ_STATUS: rdNxt = {30'h_0000_0000, irqStatus_r};
            slt_pkg::OFF_IRQ_MASK: rdNxt = {30'h_0000_0000, irqMask_r};
            default: rdNxt = slt_pkg::UNMAPPED_DATA;
        endcase
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            avs_readdata <= '0;
        end else if (avs_read && access) begin
            avs_readdata <= rdNxt;
        end
    end

    a_resync_reads0: assert property (@(posedge clk) disable iff (reset)
        (avs_read && !avs_waitrequest && avs_address == slt_pkg::OFF_CONTROL)
        |-> avs_readdata[31:24] == 8'h_00)
        else $error("control upper bits read non-zero");

    a_tx_resync: assert property (@(posedge clk) disable iff (reset)
        (avs_write && !avs_waitrequest && avs_address == slt_pkg::OFF_CONTROL
        && avs_byteenable[3] && avs_writedata[slt_pkg::BIT_TX_RESYNC]
        && (mode_r == slt_pkg::SLT_MODE_PATTERN || mode_r == slt_pkg::SLT_MODE_PRBS))
        |=> txResyncPulse)
        else $error("tx re-sync not issued");

    a_rx_resync: assert property (@(posedge clk) disable iff (reset)
        (avs_write && !avs_waitrequest && avs_address == slt_pkg::OFF_CONTROL
        && avs_byteenable[3] && avs_writedata[slt_pkg::BIT_RX_RESYNC]
        && (mode_r == slt_pkg::SLT_MODE_PATTERN || mode_r == slt_pkg::SLT_MODE_PRBS))
        |=> rxResyncPulse)
        else $error("rx re-sync not issued");

    a_resync_idle: assert property (@(posedge clk) disable iff (reset)
        !syncMode($past(mode_r)) |-> !txResyncPulse && !rxResyncPulse)
        else $error("re-sync outside sync mode");

    a_fail_sets: assert property (@(posedge clk) disable iff (reset)
        gated.err[15] |=> failFlags_r[15])
        else $error("lane failure not flagged");

    a_sync_reserved: assert property (@(posedge clk) disable iff (reset)
        (avs_read && !avs_waitrequest && avs_address == slt_pkg::OFF_SYNC)
        |-> avs_readdata[31:24] == 8'h_00)
        else $error("sync upper byte non-zero");
endmodule : slt_lane_test_status
`default_nettype wire

//--- logic/slt_pkg.sv
// Package for the serial-lane test status block: offsets, fields, resets, types.
// Assumes a 32-bit Avalon-MM register bus with byte addresses.
package slt_pkg;
    localparam int LANES = 8;
    localparam int PORTS = 3;
    localparam int ALL_LANES = LANES * PORTS;
    localparam int CNT_W = 16;
    localparam int NSEL = 3;

    localparam logic [7:0] OFF_CONTROL = 8'h_00bc;
    localparam logic [7:0] OFF_FAIL = 8'h_00c0;
    localparam logic [7:0] OFF_SYNC = 8'h_00c4;
    localparam logic [7:0] OFF_SELECT = 8'h_00c8;
    localparam logic [7:0] OFF_COUNT0 = 8'h_00cc;
    localparam logic [7:0] OFF_COUNT1 = 8'h_00d0;
    localparam logic [7:0] OFF_MODE = 8'h_00e0;
    localparam logic [7:0] OFF_IRQ_STATUS = 8'h_00e4;
    localparam logic [7:0] OFF_IRQ_MASK = 8'h_00e8;

    localparam int BIT_TX_RESYNC = 25;
    localparam int BIT_RX_RESYNC = 26;
    localparam int ENABLE_LSB = 0;
    localparam int SEL_STRIDE = 5;
    localparam int LSEL_W = 3;
    localparam int PSEL_W = 2;
    localparam int SELECT_W = NSEL * SEL_STRIDE;
    localparam int IRQ_W = 2;
    localparam int IRQ_FAIL = 0;
    localparam int IRQ_SYNC = 1;

    localparam logic [23:0] RESET_ENABLE = 24'h_ff_ffff;
    localparam logic [23:0] RESET_FLAGS = 24'h_00_0000;
    localparam logic [14:0] RESET_SELECT = 15'h_0000;
    localparam logic [15:0] RESET_COUNT = 16'h_0000;
    localparam logic [1:0] RESET_MODE = 2'h_0;
    localparam logic [31:0] UNMAPPED_DATA = 32'h_0000_0000;

    typedef enum logic [1:0] {
        SLT_PORT_A = 2'b00,
        SLT_PORT_B = 2'b01,
        SLT_PORT_C = 2'b10,
        SLT_PORT_RSVD = 2'b11
    } slt_port_t;

    typedef enum logic [1:0] {
        SLT_MODE_NORMAL = 2'b00,
        SLT_MODE_PATTERN = 2'b01,
        SLT_MODE_PRBS = 2'b10,
        SLT_MODE_LOOP = 2'b11
    } slt_mode_t;

    // Port sits above lane, as in each five-bit selector field
    typedef struct packed {
        slt_port_t port;
        logic [LSEL_W-1:0] lane;
    } slt_sel_t;

    typedef struct packed {
        logic [ALL_LANES-1:0] err;
        logic [ALL_LANES-1:0] synced;
    } slt_lane_stat_t;
endpackage : slt_pkg
